// File: src/clk_div_bank_defines.vh
// Constants shared by the output clock divider bank
`ifndef CLK_DIV_BANK_DEFINES_VH
`define CLK_DIV_BANK_DEFINES_VH

// Number of output channels
`define NUM_CHAN        5
// Config port address width and data width
`define CFG_AW          8
`define CFG_DW          8

// Divider count registers, one per output, channel zero in the low byte
`define OUTPUT_CHANNEL_ZERO_DIV_ADDR   8'h4a
`define OUTPUT_CHANNEL_ONE_DIV_ADDR   8'h4c
`define OUTPUT_CHANNEL_TWO_DIV_ADDR   8'h4e
`define OUTPUT_CHANNEL_THREE_DIV_ADDR   8'h50
`define OUTPUT_CHANNEL_FOUR_DIV_ADDR   8'h52
`define DIV_ADDR_TABLE  {`OUTPUT_CHANNEL_FOUR_DIV_ADDR, `OUTPUT_CHANNEL_THREE_DIV_ADDR, `OUTPUT_CHANNEL_TWO_DIV_ADDR, `OUTPUT_CHANNEL_ONE_DIV_ADDR, `OUTPUT_CHANNEL_ZERO_DIV_ADDR}

// Field layout of a divider count register
`define HIGH_CNT_LSB    0
`define HIGH_CNT_MSB    3
`define LOW_CNT_LSB     4
`define LOW_CNT_MSB     7
`define CNT_W           4

// Reset value of each divider count register
`define DIV_REG_RESET   8'h00

// Pin synchroniser idle level of the align input
`define ALIGN_IDLE      1'b1

`endif

// File: src/output_clock_divider_bank.v
// Five-channel programmable output clock divider bank
`include "clk_div_bank_defines.vh"

// How it works
// - Five outputs, each with own divider
// - Bypass on a powered channel passes selected input clock unchanged
// - Bypassed divider halts its counting logic
// - Every ratio from 1 to 32
// - Ratio one only through bypass
// - High count bits 3:0, low 7:4
// - Registers at even addresses 4Ah to 52h
// - Period equals high+1 plus low+1
// - High for high+1, low for low+1
// - Ratio, phase, duty set per divider
// - Align low holds output at start level
// - Align rise restarts after phase offset cycles
// - Align acts on powered, unmasked, unbypassed only
module output_clock_divider_bank
(
  input  wire                      clk_sys_i,
  input  wire                      rst_i,
  input  wire [`CFG_AW-1:0]        cfg_addr_i,
  input  wire [`CFG_DW-1:0]        cfg_wdata_i,
  input  wire                      cfg_wr_i,
  input  wire                      cfg_rd_i,
  output wire [`CFG_DW-1:0]        cfg_rdata_o,
  output wire                      cfg_rvalid_o,
  input  wire                      divider_align_n_i,
  input  wire [`NUM_CHAN-1:0]      chan_bypass_i,
  input  wire [`NUM_CHAN-1:0]      chan_pd_i,
  input  wire [`NUM_CHAN-1:0]      chan_nosync_i,
  input  wire [`NUM_CHAN-1:0]      chan_start_high_i,
  input  wire [`NUM_CHAN*4-1:0]    chan_phase_i,
  output wire [`NUM_CHAN-1:0]      chan_running_o,
  output wire                      output_channel_zero_o,
  output wire                      output_channel_one_o,
  output wire                      output_channel_two_o,
  output wire                      output_channel_three_o,
  output wire                      output_channel_four_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants
  localparam [`NUM_CHAN*8-1:0] ADDR_TABLE = `DIV_ADDR_TABLE;

  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_HOLD  = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_HIGH  = 3'h3;
  localparam [2:0] ST_LOW   = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Signals
  wire                      align_lvl;
  reg                       align_prev_r;
  wire                      align_rise;
  wire [`NUM_CHAN*8-1:0]    rd_terms;
  reg  [`CFG_DW-1:0]        rd_any;
  reg  [`CFG_DW-1:0]        cfg_rdata_r;
  reg                       cfg_rvalid_r;
  wire [`NUM_CHAN-1:0]      div_q;
  wire [`NUM_CHAN-1:0]      run_q;
  wire [`NUM_CHAN-1:0]      pass_sel;
  integer                   k;

  ////////////////////////////////////////////////////////////////////////////
  // Align pin synchroniser and rising edge detect
  pin_sync3 u_align_sync
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     (divider_align_n_i),
    .level_o   (align_lvl)
  );

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      align_prev_r <= `ALIGN_IDLE;
    end
    else
    begin
      align_prev_r <= align_lvl;
    end
  end

  assign align_rise = align_lvl & ~align_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel register and divider
  genvar g;
  generate
    for (g = 0; g < `NUM_CHAN; g = g + 1)
    begin : chan
      reg  [7:0]         div_reg_r;
      reg  [2:0]         st_r;
      reg  [2:0]         st_nxt;
      reg  [`CNT_W-1:0]  cnt_r;
      reg  [`CNT_W-1:0]  cnt_nxt;
      reg  [`CNT_W-1:0]  hi_r;
      reg  [`CNT_W-1:0]  hi_nxt;
      reg  [`CNT_W-1:0]  lo_r;
      reg  [`CNT_W-1:0]  lo_nxt;
      reg                out_r;
      reg                out_nxt;
      reg                run_r;
      wire               hit;
      wire               halted;
      wire               affected;
      wire [`CNT_W-1:0]  reg_hi;
      wire [`CNT_W-1:0]  reg_lo;
      wire [`CNT_W-1:0]  phase;
      wire               start_high;

      assign hit        = (cfg_addr_i == ADDR_TABLE[8*g +: 8]);
      assign reg_hi     = div_reg_r[`HIGH_CNT_MSB:`HIGH_CNT_LSB];
      assign reg_lo     = div_reg_r[`LOW_CNT_MSB:`LOW_CNT_LSB];
      assign phase      = chan_phase_i[4*g +: 4];
      assign start_high = chan_start_high_i[g];
      assign halted     = chan_pd_i[g] | chan_bypass_i[g];
      assign affected   = ~chan_pd_i[g] & ~chan_nosync_i[g]
                          & ~chan_bypass_i[g];

      // Count register write
      always @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          div_reg_r <= `DIV_REG_RESET;
        end
        else if (cfg_wr_i && hit)
        begin
          div_reg_r <= cfg_wdata_i;
        end
      end

      assign rd_terms[8*g +: 8] = hit ? div_reg_r : 8'h00;

      // Divider next state
      always @*
      begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        hi_nxt  = hi_r;
        lo_nxt  = lo_r;
        out_nxt = out_r;
        if (halted)
        begin
          st_nxt  = ST_OFF;
          cnt_nxt = {`CNT_W{1'b0}};
          out_nxt = 1'b0;
        end
        else if (affected && !align_lvl)
        begin
          st_nxt  = ST_HOLD;
          cnt_nxt = {`CNT_W{1'b0}};
          out_nxt = start_high;
        end
        else if (affected && align_rise)
        begin
          st_nxt  = ST_DELAY;
          cnt_nxt = phase;
          out_nxt = start_high;
        end
        else
        begin
          case (st_r)
            ST_OFF:
            begin
              st_nxt  = ST_DELAY;
              cnt_nxt = {`CNT_W{1'b0}};
            end
            ST_HOLD:
            begin
              st_nxt  = ST_DELAY;
              cnt_nxt = {`CNT_W{1'b0}};
            end
            ST_DELAY:
            begin
              if (cnt_r == {`CNT_W{1'b0}})
              begin
                hi_nxt = reg_hi;
                lo_nxt = reg_lo;
                if (start_high)
                begin
                  st_nxt  = ST_HIGH;
                  cnt_nxt = reg_hi;
                  out_nxt = 1'b1;
                end
                else
                begin
                  st_nxt  = ST_LOW;
                  cnt_nxt = reg_lo;
                  out_nxt = 1'b0;
                end
              end
              else
              begin
                cnt_nxt = cnt_r - 1'b1;
              end
            end
            ST_HIGH:
            begin
              if (cnt_r == {`CNT_W{1'b0}})
              begin
                st_nxt  = ST_LOW;
                cnt_nxt = lo_r;
                out_nxt = 1'b0;
              end
              else
              begin
                cnt_nxt = cnt_r - 1'b1;
              end
            end
            ST_LOW:
            begin
              if (cnt_r == {`CNT_W{1'b0}})
              begin
                hi_nxt  = reg_hi;
                lo_nxt  = reg_lo;
                st_nxt  = ST_HIGH;
                cnt_nxt = reg_hi;
                out_nxt = 1'b1;
              end
              else
              begin
                cnt_nxt = cnt_r - 1'b1;
              end
            end
            default:
            begin
              st_nxt  = ST_OFF;
              cnt_nxt = {`CNT_W{1'b0}};
              out_nxt = 1'b0;
            end
          endcase
        end
      end

      // Divider state registers
      always @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          st_r  <= ST_OFF;
          cnt_r <= {`CNT_W{1'b0}};
          hi_r  <= {`CNT_W{1'b0}};
          lo_r  <= {`CNT_W{1'b0}};
          out_r <= 1'b0;
          run_r <= 1'b0;
        end
        else
        begin
          st_r  <= st_nxt;
          cnt_r <= cnt_nxt;
          hi_r  <= hi_nxt;
          lo_r  <= lo_nxt;
          out_r <= out_nxt;
          run_r <= (st_nxt == ST_HIGH) || (st_nxt == ST_LOW);
        end
      end

      assign div_q[g]    = out_r;
      assign run_q[g]    = run_r;
      assign pass_sel[g] = chan_bypass_i[g] & ~chan_pd_i[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Config read-back, unmapped addresses read as zero
  always @*
  begin
    rd_any = {`CFG_DW{1'b0}};
    for (k = 0; k < `NUM_CHAN; k = k + 1)
    begin
      rd_any = rd_any | rd_terms[8*k +: 8];
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cfg_rdata_r  <= {`CFG_DW{1'b0}};
      cfg_rvalid_r <= 1'b0;
    end
    else
    begin
      cfg_rvalid_r <= cfg_rd_i;
      if (cfg_rd_i)
      begin
        cfg_rdata_r <= rd_any;
      end
    end
  end

  assign cfg_rdata_o    = cfg_rdata_r;
  assign cfg_rvalid_o   = cfg_rvalid_r;
  assign chan_running_o = run_q;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: bypass on a powered channel passes the input clock straight through
  assign output_channel_zero_o  = pass_sel[0] ? clk_sys_i : div_q[0];
  assign output_channel_one_o   = pass_sel[1] ? clk_sys_i : div_q[1];
  assign output_channel_two_o   = pass_sel[2] ? clk_sys_i : div_q[2];
  assign output_channel_three_o = pass_sel[3] ? clk_sys_i : div_q[3];
  assign output_channel_four_o  = pass_sel[4] ? clk_sys_i : div_q[4];

endmodule // output_clock_divider_bank

// File: src/pin_sync3.v
// Three-stage pin synchroniser with agreement filter
`include "clk_div_bank_defines.vh"

module pin_sync3
(
  input  wire clk_sys_i,
  input  wire rst_i,
  input  wire pin_i,
  output wire level_o
);

  reg stage1_r;
  reg stage2_r;
  reg stage3_r;
  reg level_r;

  ////////////////////////////////////////////////////////////////////////////
  // Three flops, change accepted once stages two and three agree
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      stage1_r <= `ALIGN_IDLE;
      stage2_r <= `ALIGN_IDLE;
      stage3_r <= `ALIGN_IDLE;
      level_r  <= `ALIGN_IDLE;
    end
    else
    begin
      stage1_r <= pin_i;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r)
      begin
        level_r <= stage3_r;
      end
    end
  end

  assign level_o = level_r;

endmodule // pin_sync3

// File: testbench/clk_sink.sv
// Converter clock sink that measures high and low spans of its clock
module clk_sink
(
  input  logic       clk_sys_i,
  input  logic       ck_i,
  output logic [7:0] hi_len_o,
  output logic [7:0] lo_len_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_r = 8'h01;
  logic       prev_r = 1'b0;
  initial hi_len_o = 8'h00;
  initial lo_len_o = 8'h00;
  always @(posedge clk_sys_i)
  begin
    prev_r <= ck_i;
    if (ck_i == prev_r)
      run_r <= run_r + 8'h01;
    else
    begin
      run_r <= 8'h01;
      if (prev_r)
        hi_len_o <= run_r;
      else
        lo_len_o <= run_r;
    end
  end
endmodule // clk_sink

// File: testbench/output_clock_divider_bank_sva.sv
// Port assertions for the output clock divider bank
module output_clock_divider_bank_sva
(
  input logic       clk_sys_i,
  input logic       rst_i,
  input logic [7:0] cfg_addr_i,
  input logic [7:0] cfg_wdata_i,
  input logic       cfg_wr_i,
  input logic       cfg_rd_i,
  input logic [7:0] cfg_rdata_o,
  input logic       cfg_rvalid_o,
  input logic       divider_align_n_i,
  input logic [4:0] chan_bypass_i,
  input logic [4:0] chan_pd_i,
  input logic [4:0] chan_nosync_i,
  input logic [4:0] chan_start_high_i,
  input logic [4:0] chan_running_o,
  input logic       output_channel_zero_o,
  input logic       output_channel_two_o,
  input logic       output_channel_four_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] hi_run_r;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Length of the running high interval of channel four
  always @(posedge clk_sys_i)
    if (rst_i || !output_channel_four_o || !chan_running_o[4])
      hi_run_r <= 6'h00;
    else
      hi_run_r <= hi_run_r + 6'h01;
  a_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (cfg_rvalid_o |-> $past(cfg_rd_i))
    else $error("read valid without read");
  a_unmapped_zero: assert property (cfg_rd_i && !(cfg_addr_i inside
    {8'h4a, 8'h4c, 8'h4e, 8'h50, 8'h52}) |=> cfg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_write_readback: assert property (cfg_wr_i && cfg_addr_i == 8'h4a
    ##1 cfg_rd_i && cfg_addr_i == 8'h4a |=> cfg_rdata_o == $past(cfg_wdata_i, 2))
    else $error("readback differs");
  a_rdata_steady: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data moved");
  a_bypass_halts: assert property (chan_bypass_i[3] [*2] |->
    !chan_running_o[3])
    else $error("bypassed divider counts");
  a_pd_silent: assert property (chan_pd_i[2] [*2] |->
    !output_channel_two_o && !chan_running_o[2])
    else $error("powered down channel active");
  a_hold_level: assert property ((!divider_align_n_i && !chan_pd_i[0] &&
    !chan_nosync_i[0] && !chan_bypass_i[0]) [*8] |->
    output_channel_zero_o == chan_start_high_i[0])
    else $error("hold level wrong");
  a_high_span: assert property (hi_run_r <= 6'h10)
    else $error("high interval too long");
  c_bypass: cover property (chan_bypass_i[3] [*2]);
  c_hold: cover property (!divider_align_n_i [*8]);
  c_read: cover property (cfg_wr_i ##2 cfg_rvalid_o);
endmodule // output_clock_divider_bank_sva

bind output_clock_divider_bank output_clock_divider_bank_sva chk (.*);

// File: testbench/test_output_clock_divider_bank.sv
// Self-checking bench of the output clock divider bank
module test_output_clock_divider_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  cfg_addr_i = 8'h00;
  logic [7:0]  cfg_wdata_i = 8'h00;
  logic        cfg_wr_i = 1'b0;
  logic        cfg_rd_i = 1'b0;
  logic        divider_align_n_i = 1'b1;
  logic [4:0]  chan_bypass_i = 5'h00;
  logic [4:0]  chan_pd_i = 5'h00;
  logic [4:0]  chan_nosync_i = 5'h00;
  logic [4:0]  chan_start_high_i = 5'h00;
  logic [19:0] chan_phase_i = 20'h00000;
  wire  [7:0]  cfg_rdata_o;
  wire         cfg_rvalid_o;
  wire  [4:0]  chan_running_o;
  wire         output_channel_zero_o;
  wire         output_channel_one_o;
  wire         output_channel_two_o;
  wire         output_channel_three_o;
  wire         output_channel_four_o;
  wire  [4:0]  outs = {output_channel_four_o, output_channel_three_o,
    output_channel_two_o, output_channel_one_o, output_channel_zero_o};
  wire  [4:0][7:0] hl;
  wire  [4:0][7:0] ll;
  logic [7:0]  regv [5];
  int          error_cnt = 0;
  int          check_count = 0;
  int          i;
  int          c;

  output_clock_divider_bank dut (.*);
  for (genvar g = 0; g < 5; g++)
  begin : g_sink
    clk_sink sink (.clk_sys_i, .ck_i(outs[g]), .hi_len_o(hl[g]),
      .lo_len_o(ll[g]));
  end

  always #12.5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bus tasks start just after a falling edge and end on one
  // Strobes stay up until the next call or an explicit idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    cfg_rd_i = 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    cfg_wr_i = 1'b0;
    @(negedge clk_sys_i);
    chk(8'(cfg_rvalid_o), 8'h01);
    chk(cfg_rdata_o, exp);
  endtask

  function automatic logic [7:0] reg_addr(input int n);
    return 8'h4a + 8'(2 * n);
  endfunction

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(32'h4df6));
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (c = 0; c < 5; c++)
      rd(reg_addr(c), 8'h00);
    wr(8'h4b, 8'h5a);
    rd(8'h4b, 8'h00);
    for (i = 0; i < 6; i++)
    begin
      for (c = 0; c < 5; c++)
      begin
        regv[c] = (i == 0) ? 8'hff : (i == 1) ? 8'h0f : 8'($urandom);
        wr(reg_addr(c), regv[c]);
        rd(reg_addr(c), regv[c]);
      end
      cfg_rd_i = 1'b0;
      repeat (120) @(negedge clk_sys_i);
      for (c = 0; c < 5; c++)
      begin
        chk(hl[c], {4'h0, regv[c][3:0]} + 8'h01);
        chk(ll[c], {4'h0, regv[c][7:4]} + 8'h01);
      end
    end
    // Rewrite channel four mid-period: no interval may come out cut short
    wr(reg_addr(4), 8'h77);
    cfg_wr_i = 1'b0;
    i = 0;
    for (c = 0; c < 64; c++)
    begin
      @(negedge clk_sys_i);
      if (hl[4] !== {4'h0, regv[4][3:0]} + 8'h01 && hl[4] !== 8'h08)
        i++;
      if (ll[4] !== {4'h0, regv[4][7:4]} + 8'h01 && ll[4] !== 8'h08)
        i++;
    end
    chk(8'(i), 8'h00);
    chan_bypass_i = 5'h08;
    repeat (3) @(negedge clk_sys_i);
    #1;
    chk(8'(outs[3]), 8'h00);
    @(posedge clk_sys_i);
    #1;
    chk(8'(outs[3]), 8'h01);
    chk(8'(chan_running_o[3]), 8'h00);
    @(negedge clk_sys_i);
    chan_start_high_i = 5'h05;
    chan_nosync_i = 5'h02;
    chan_pd_i = 5'h04;
    chan_phase_i = 20'h00003;
    divider_align_n_i = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    chk(8'(outs[0]), 8'h01);
    chk(8'(outs[4]), 8'h00);
    chk(8'(chan_running_o[0]), 8'h00);
    chk(8'(chan_running_o[2]), 8'h00);
    chk(8'(chan_running_o[1]), 8'h01);
    divider_align_n_i = 1'b1;
    i = 0;
    for (c = 0; c < 40; c++)
    begin
      @(negedge clk_sys_i);
      if (chan_running_o[4] === 1'b1 && chan_running_o[0] !== 1'b1)
        i++;
    end
    chk(8'(i), 8'h03);
    give_verdict();
  end
endmodule // test_output_clock_divider_bank
